/* bench/sbh_sva.sv */
// Concurrent checks on the link between the device end and the agent end
`timescale 1ns/1ns
module sbh_sva
    import sbh_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Link signals
    input wire logic ad_dev_oe,
    input wire logic ad_agt_oe,
    input wire logic outbound_valid_n,
    input wire logic outbound_valid_oe,
    input wire logic release_n,
    input wire logic release_oe,
    input wire logic ref_tick,
    input wire logic agent_request_n,
    input wire logic inbound_valid_n,
    input wire logic command_parity_bit,
    input wire logic [SBH_CMD_W-1:0] sys_command_id
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // Steps of a read hand-over and of a grant
    sequence s_read_addr;
        ad_dev_oe && !outbound_valid_n && sys_command_id == SBH_CMD_READ;
    endsequence
    sequence s_granted;
        !release_n && release_oe;
    endsequence

    // Bounds allow for a read in flight ahead of the grant
    property p_grant;
        $fell(agent_request_n) |-> ##[1:64] s_granted;
    endproperty
    a_grant: assert property (p_grant) else $error("agent request not granted");
    property p_read_rel;
        s_read_addr |-> ##[1:16] s_granted;
    endproperty
    a_read_rel: assert property (p_read_rel) else $error("no release after read address");
    property p_in_valid;
        !inbound_valid_n |-> ad_agt_oe;
    endproperty
    a_in_valid: assert property (p_in_valid) else $error("inbound strobe without agent drive");
    property p_out_valid;
        outbound_valid_oe && !outbound_valid_n |-> ad_dev_oe;
    endproperty
    a_out_valid: assert property (p_out_valid) else $error("outbound strobe without device drive");
    property p_out_exact;
        ad_dev_oe |-> !outbound_valid_n;
    endproperty
    a_out_exact: assert property (p_out_exact) else $error("device drives without strobe");
    property p_parity;
        command_parity_bit == 1'b0;
    endproperty
    a_parity: assert property (p_parity) else $error("command parity not low");
    property p_tick;
        $changed(outbound_valid_n) |-> $past(ref_tick);
    endproperty
    a_tick: assert property (p_tick) else $error("strobe moved off a reference tick");
    property p_reset_float;
        disable iff (1'b0) i_srst |=> !ad_dev_oe && !ad_agt_oe;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("bus driven in reset");
    property p_one_drv;
        !(ad_dev_oe && ad_agt_oe);
    endproperty
    a_one_drv: assert property (p_one_drv) else $error("two drivers on the bus");
    property p_handover;
        ad_agt_oe |-> s_granted;
    endproperty
    a_handover: assert property (p_handover) else $error("agent drives without release");
endmodule

/* bench/sbh_tb.sv */
// Self-checking bench joining the device end and the agent end
`timescale 1ns/1ns
module sbh_tb;
    import sbh_pkg::*;
    logic i_clk = 0, i_srst = 1, i_pwr_n = 0, stall = 0;
    logic i_req_valid = 0, i_req_write = 0, o_req_ready, o_rsp_valid, i_rd_ready = 0, i_wr_ready = 0;
    logic [31:0] i_req_addr = 0, o_rd_addr, o_wr_addr, seed = 32'h0000_0007;
    logic [63:0] i_req_data = 0, o_rsp_data, i_rd_data, o_wr_data, i_tx_data = 0;
    logic [8:0] o_rsp_cmd, i_tx_cmd = 0;
    logic o_rd_pending, o_wr_valid, i_tx_valid = 0, o_tx_done;
    logic [63:0] wq_a[$], wq_d[$], rq_c[$], rq_d[$], rq_a[$];
    int fails = 0, n_checks = 0, n;
    bit ok;
    logic pend_q = 0;
    sbh_if sbh_if_i ();
    // Clock at 250 MHz
    always #2 i_clk = ~i_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Memory contents seen by the agent; a fixed function of the address
    function automatic logic [63:0] rd_word(input logic [31:0] a);
        return {a ^ 32'h5A5A_C3C3, ~a};
    endfunction
    function automatic logic [7:0] par(input logic [63:0] w);
        for (int i = 0; i < 8; i++) par[i] = ^w[i*8 +: 8];
    endfunction
    assign i_rd_data = rd_word(o_rd_addr);
    sbh_device sbh_device_i (.i_clk(i_clk), .i_srst(i_srst), .i_power_up_reset_n(i_pwr_n),
        .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
        .i_req_data(i_req_data), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
        .o_rsp_data(o_rsp_data), .o_rsp_cmd(o_rsp_cmd), .link(sbh_if_i.device));
    sbh_agent sbh_agent_i (.i_clk(i_clk), .i_srst(i_srst), .i_rd_ready(i_rd_ready),
        .i_wr_ready(i_wr_ready), .o_rd_pending(o_rd_pending), .o_rd_addr(o_rd_addr),
        .i_rd_data(i_rd_data), .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
        .i_tx_valid(i_tx_valid), .i_tx_cmd(i_tx_cmd), .i_tx_data(i_tx_data), .o_tx_done(o_tx_done),
        .link(sbh_if_i.agent));
    sbh_sva sbh_sva_i (.i_clk(i_clk), .i_srst(i_srst), .ad_dev_oe(sbh_if_i.ad_dev_oe),
        .ad_agt_oe(sbh_if_i.ad_agt_oe), .outbound_valid_n(sbh_if_i.outbound_valid_n),
        .outbound_valid_oe(sbh_if_i.outbound_valid_oe), .release_n(sbh_if_i.release_n),
        .release_oe(sbh_if_i.release_oe), .ref_tick(sbh_if_i.ref_tick),
        .agent_request_n(sbh_if_i.agent_request_n), .inbound_valid_n(sbh_if_i.inbound_valid_n),
        .command_parity_bit(sbh_if_i.command_parity_bit), .sys_command_id(sbh_if_i.sys_command_id));
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Random accept levels from the memory side, off while stalled
    always @(negedge i_clk) begin
        i_rd_ready <= !stall && rnd() > 32'h5000_0000;
        i_wr_ready <= !stall && rnd() > 32'h5000_0000;
    end
    // Result monitor against the queued model, plus wire-level checks
    always @(negedge i_clk) if (!i_srst) begin
        if (o_wr_valid === 1'b1) begin
            chk("wr_addr", wq_a.size() ? wq_a.pop_front() : 'x, {32'h0, o_wr_addr});
            chk("wr_data", wq_d.size() ? wq_d.pop_front() : 'x, o_wr_data);
        end
        if (o_rsp_valid === 1'b1) begin
            chk("rsp_cmd", rq_c.size() ? rq_c.pop_front() : 'x, {55'h0, o_rsp_cmd});
            chk("rsp_data", rq_d.size() ? rq_d.pop_front() : 'x, o_rsp_data);
        end
        // Read address as the agent takes it, once per read
        if (o_rd_pending === 1'b1 && pend_q !== 1'b1)
            chk("rd_addr", rq_a.size() ? rq_a.pop_front() : 'x, {32'h0, o_rd_addr});
        pend_q = o_rd_pending;
        if (sbh_if_i.ad_dev_oe === 1'b1 || sbh_if_i.ad_agt_oe === 1'b1)
            chk("check_bits", par(sbh_if_i.sys_addr_data), sbh_if_i.sys_check_bits);
        if (sbh_if_i.ad_dev_oe === 1'b1)
            chk("cmd_parity", 0, sbh_if_i.command_parity_bit);
    end
    // One request, held until the FIFO takes it; valid stays up for back-to-back use
    task automatic push(input logic wr, output bit ok);
        logic [31:0] a;
        logic [63:0] d;
        int k;
        a = rnd();
        d = {rnd(), rnd()};
        k = 0;
        @(negedge i_clk);
        if (o_req_ready !== 1'b1) i_req_valid = 0;
        while (o_req_ready !== 1'b1 && k < 500) begin
            @(negedge i_clk);
            k++;
        end
        // A refused request is neither driven nor expected
        ok = (o_req_ready === 1'b1);
        if (!ok) return;
        i_req_valid = 1;
        i_req_write = wr;
        i_req_addr = a;
        i_req_data = d;
        if (wr) begin
            wq_a.push_back({32'h0, a});
            wq_d.push_back(d);
        end else begin
            rq_c.push_back({55'h0, SBH_CMD_DATA});
            rq_d.push_back(rd_word(a));
            rq_a.push_back({32'h0, a});
        end
    endtask
    task automatic drain(input string nm);
        int k;
        k = 0;
        @(negedge i_clk);
        i_req_valid = 0;
        while ((wq_a.size() || rq_c.size() || rq_a.size()) && k < 3000) begin
            @(negedge i_clk);
            k++;
        end
        chk("drained", 0, wq_a.size() + rq_c.size() + rq_a.size());
        chk("rd_idle", 0, o_rd_pending);
        $display("test %s done", nm);
    endtask
    // Watchdog: far beyond the few thousand cycles the tests need
    initial begin
        #200000;
        fails++;
        test_done();
    end
    initial begin
        repeat (3) @(negedge i_clk);
        chk("dev_oe_rst", 0, sbh_if_i.ad_dev_oe);
        i_srst = 0;
        repeat (4) @(negedge i_clk);
        chk("rel_oe_pwr", 0, {sbh_if_i.release_oe, sbh_if_i.outbound_valid_oe});
        chk("req_ready", 1, o_req_ready);
        i_pwr_n = 1;
        repeat (8) @(negedge i_clk);
        chk("idle_pins", 3, {sbh_if_i.release_pin_n, sbh_if_i.outbound_valid_pin_n});
        chk("idle_oe", 3, {sbh_if_i.release_oe, sbh_if_i.outbound_valid_oe});
        $display("test reset done");
        // Mixed reads and writes, back to back
        repeat (24) begin
            push(rnd() > 32'h8000_0000, ok);
            chk("pushed", 1, ok);
        end
        drain("mixed");
        // Stall the memory side and fill the FIFO until it refuses
        stall = 1;
        repeat (6) @(negedge i_clk);
        n = 0;
        ok = 1;
        // Ready only drops after the last word lands, so count what was taken
        while (ok && n < 20) begin
            push(n[0], ok);
            if (ok) n++;
        end
        @(negedge i_clk);
        i_req_valid = 0;
        chk("fill_count", SBH_FIFO_DEPTH, n);
        chk("accepts_off", 3, {sbh_if_i.read_accept_n, sbh_if_i.write_accept_n});
        chk("no_issue", 0, sbh_if_i.ad_dev_oe);
        stall = 0;
        drain("fill");
        // Agent-initiated words, the first racing device writes
        for (int t = 0; t < 4; t++) begin
            if (t == 0) repeat (4) push(1'b1, ok);
            @(negedge i_clk);
            i_req_valid = 0;
            i_tx_valid = 1;
            i_tx_cmd = 9'(rnd());
            i_tx_data = {rnd(), rnd()};
            rq_c.push_back({55'h0, i_tx_cmd});
            rq_d.push_back(i_tx_data);
            n = 0;
            while (o_tx_done !== 1'b1 && n < 500) begin
                @(negedge i_clk);
                n++;
            end
            chk("tx_done", 1, o_tx_done);
            i_tx_valid = 0;
        end
        drain("agent");
        // Second reset in mid-run
        i_srst = 1;
        repeat (3) @(negedge i_clk);
        chk("reset_again", 0, {sbh_if_i.ad_dev_oe, sbh_if_i.ad_agt_oe, o_req_ready});
        i_srst = 0;
        repeat (4) @(negedge i_clk);
        $display("test second_reset done");
        test_done();
    end
endmodule

/* design/sbh_agent.sv */
// External agent end of the system bus handshake
`timescale 1ns/1ns
module sbh_agent
    import sbh_pkg::*;
#(
    parameter bit WIDE = 1'b1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Flow control from the memory side
    input wire logic i_rd_ready,
    input wire logic i_wr_ready,
    // Read service
    output logic o_rd_pending,
    output logic [SBH_ADDR_W-1:0] o_rd_addr,
    input wire logic [SBH_AD_W-1:0] i_rd_data,
    // Writes from the device
    output logic o_wr_valid,
    output logic [SBH_ADDR_W-1:0] o_wr_addr,
    output logic [SBH_AD_W-1:0] o_wr_data,
    // Agent-initiated word
    input wire logic i_tx_valid,
    input wire logic [SBH_CMD_W-1:0] i_tx_cmd,
    input wire logic [SBH_AD_W-1:0] i_tx_data,
    output logic o_tx_done,
    // Link
    sbh_if.agent link
);
    logic wr_expect;

    wire dev_valid = !link.outbound_valid_pin_n;
    wire granted = !link.release_pin_n;
    wire [SBH_CMD_W-1:0] cmd_in = link.sys_command_id;
    wire [SBH_AD_W-1:0] rd_word = sbh_lane(i_rd_data, WIDE);
    wire [SBH_AD_W-1:0] tx_word = sbh_lane(i_tx_data, WIDE);
    // Only drive while released and while our own request or read is open
    wire send_rd = o_rd_pending && granted;
    wire send_tx = !o_rd_pending && granted && !link.agent_request_n && i_tx_valid;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            link.ad_agt <= '0;
            link.ad_agt_oe <= 1'b0;
            link.chk_agt <= '0;
            link.cmd_agt <= '0;
            link.agent_request_n <= 1'b1;
            link.read_accept_n <= 1'b1;
            link.write_accept_n <= 1'b1;
            link.inbound_valid_n <= 1'b1;
            wr_expect <= 1'b0;
            o_rd_pending <= 1'b0;
            o_rd_addr <= '0;
            o_wr_valid <= 1'b0;
            o_wr_addr <= '0;
            o_wr_data <= '0;
            o_tx_done <= 1'b0;
        end else begin
            o_wr_valid <= 1'b0;
            o_tx_done <= 1'b0;
            if (link.ref_tick) begin
                // One read outstanding at a time
                link.read_accept_n <= !(i_rd_ready && !o_rd_pending);
                link.write_accept_n <= !i_wr_ready;
                link.ad_agt_oe <= 1'b0;
                link.inbound_valid_n <= 1'b1;
                link.agent_request_n <= !(i_tx_valid && !o_rd_pending);
                if (dev_valid) begin
                    if (cmd_in == SBH_CMD_READ) begin
                        o_rd_pending <= 1'b1;
                        o_rd_addr <= link.sys_addr_data[SBH_ADDR_W-1:0];
                    end else if (cmd_in == SBH_CMD_WRITE) begin
                        wr_expect <= 1'b1;
                        o_wr_addr <= link.sys_addr_data[SBH_ADDR_W-1:0];
                    end else if (cmd_in == SBH_CMD_DATA && wr_expect) begin
                        wr_expect <= 1'b0;
                        o_wr_valid <= 1'b1;
                        o_wr_data <= sbh_lane(link.sys_addr_data, WIDE);
                    end
                end
                if (send_rd) begin
                    link.ad_agt <= rd_word;
                    link.chk_agt <= sbh_check(rd_word, WIDE);
                    link.cmd_agt <= SBH_CMD_DATA;
                    link.ad_agt_oe <= 1'b1;
                    link.inbound_valid_n <= 1'b0;
                    o_rd_pending <= 1'b0;
                end else if (send_tx) begin
                    link.ad_agt <= tx_word;
                    link.chk_agt <= sbh_check(tx_word, WIDE);
                    link.cmd_agt <= i_tx_cmd;
                    link.ad_agt_oe <= 1'b1;
                    link.inbound_valid_n <= 1'b0;
                    link.agent_request_n <= 1'b1;
                    o_tx_done <= 1'b1;
                end
            end
        end
    end
endmodule

/* design/sbh_device.sv */
// Device end of the system bus handshake with its request FIFO
`timescale 1ns/1ns
module sbh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;
    wire [PTR_W:0] next_count = count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

    assign o_valid = (count != '0);
    assign o_data = mem[rd_ptr];

    // Pointers wrap; depth is expected to be a power of two
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            o_ready <= 1'b0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= i_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            // Registered ready: full is known one cycle ahead
            o_ready <= (next_count != DEPTH[PTR_W:0]);
        end
    end
endmodule

module sbh_device
    import sbh_pkg::*;
#(
    parameter int CLK_MULT = SBH_MULT_DEF,
    parameter bit WIDE = 1'b1,
    parameter int DEPTH = SBH_FIFO_DEPTH
) (
    // Clock and resets
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_power_up_reset_n,
    // Request side from the core
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [SBH_ADDR_W-1:0] i_req_addr,
    input wire logic [SBH_AD_W-1:0] i_req_data,
    output logic o_req_ready,
    // Inbound words to the core
    output logic o_rsp_valid,
    output logic [SBH_AD_W-1:0] o_rsp_data,
    output logic [SBH_CMD_W-1:0] o_rsp_cmd,
    // Link
    sbh_if.device link
);
    localparam int REQ_W = 1 + SBH_ADDR_W + SBH_AD_W;
    localparam int CNT_W = $clog2(SBH_MULT_MAX);

    typedef enum logic [1:0] {ST_IDLE, ST_WR_DATA, ST_RD_WAIT, ST_GRANT} sbh_dev_state_t;
    sbh_dev_state_t state;

    logic [CNT_W-1:0] mult_cnt;
    logic tick;
    logic [2:0] pwr_sync;
    logic pwr_ok;
    logic f_valid;
    logic [REQ_W-1:0] f_data;
    logic [SBH_AD_W-1:0] wr_data_hold;

    // Reference period in pipeline cycles, limited to two..eight
    localparam logic [CNT_W-1:0] MULT_LAST = CNT_W'(((CLK_MULT < SBH_MULT_MIN) ? SBH_MULT_MIN :
        (CLK_MULT > SBH_MULT_MAX) ? SBH_MULT_MAX : CLK_MULT) - 1);

    // FIFO word fields
    wire f_write = f_data[REQ_W-1];
    wire [SBH_ADDR_W-1:0] f_addr = f_data[SBH_AD_W +: SBH_ADDR_W];
    wire [SBH_AD_W-1:0] f_wdata = f_data[SBH_AD_W-1:0];
    wire agent_wants = !link.agent_request_n;
    wire accepted = f_write ? !link.write_accept_n : !link.read_accept_n;
    // Agent request wins over our own traffic so it is never starved
    wire take = tick && (state == ST_IDLE) && !agent_wants && f_valid && accepted;
    wire inbound = !link.inbound_valid_n;
    wire [SBH_AD_W-1:0] addr_word = {SBH_UPPER_ZERO, f_addr};
    wire [CNT_W-1:0] next_mult_cnt = (mult_cnt == MULT_LAST) ? '0 : mult_cnt + 1'b1;

    sbh_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(DEPTH)
    ) u_req_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_valid(i_req_valid),
        .i_data({i_req_write, i_req_addr, i_req_data}),
        .o_ready(o_req_ready),
        .o_valid(f_valid),
        .o_data(f_data),
        .i_ready(take)
    );

    // Reference-cycle strobe: link pins move once per reference period
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mult_cnt <= '0;
            tick <= 1'b0;
        end else begin
            mult_cnt <= next_mult_cnt;
            tick <= (next_mult_cnt == '0);
        end
    end
    assign link.ref_tick = tick;

    // Power-up reset pin is asynchronous; change taken when stages two and three agree
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pwr_sync <= 3'h0;
            pwr_ok <= 1'b0;
            link.outbound_valid_oe <= 1'b0;
            link.release_oe <= 1'b0;
        end else begin
            pwr_sync <= {pwr_sync[1:0], i_power_up_reset_n};
            if (pwr_sync[2] == pwr_sync[1]) begin
                pwr_ok <= pwr_sync[2];
            end
            link.outbound_valid_oe <= pwr_ok;
            link.release_oe <= pwr_ok;
        end
    end

    // Link state machine; only acts on reference ticks
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= ST_IDLE;
            link.ad_dev <= '0;
            link.ad_dev_oe <= 1'b0;
            link.chk_dev <= '0;
            link.cmd_dev <= '0;
            link.outbound_valid_n <= 1'b1;
            link.release_n <= 1'b1;
            wr_data_hold <= '0;
            o_rsp_valid <= 1'b0;
            o_rsp_data <= '0;
            o_rsp_cmd <= '0;
        end else begin
            o_rsp_valid <= 1'b0;
            if (tick) begin
                case (state)
                    ST_IDLE: begin
                        link.outbound_valid_n <= 1'b1;
                        link.ad_dev_oe <= 1'b0;
                        if (agent_wants) begin
                            link.release_n <= 1'b0;
                            state <= ST_GRANT;
                        end else if (take) begin
                            link.ad_dev <= addr_word;
                            link.chk_dev <= sbh_check(addr_word, WIDE);
                            link.cmd_dev <= f_write ? SBH_CMD_WRITE : SBH_CMD_READ;
                            link.outbound_valid_n <= 1'b0;
                            link.ad_dev_oe <= 1'b1;
                            wr_data_hold <= sbh_lane(f_wdata, WIDE);
                            state <= f_write ? ST_WR_DATA : ST_RD_WAIT;
                        end
                    end
                    ST_WR_DATA: begin
                        link.ad_dev <= wr_data_hold;
                        link.chk_dev <= sbh_check(wr_data_hold, WIDE);
                        link.cmd_dev <= SBH_CMD_DATA;
                        link.outbound_valid_n <= 1'b0;
                        state <= ST_IDLE;
                    end
                    ST_RD_WAIT: begin
                        // Float and release on the same tick; the agent drives a tick later, so the two drivers never overlap
                        link.outbound_valid_n <= 1'b1;
                        link.ad_dev_oe <= 1'b0;
                        link.release_n <= 1'b0;
                        if (!link.release_n && inbound) begin
                            o_rsp_valid <= 1'b1;
                            o_rsp_data <= sbh_lane(link.sys_addr_data, WIDE);
                            o_rsp_cmd <= link.sys_command_id;
                            link.release_n <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                    ST_GRANT: begin
                        if (inbound) begin
                            o_rsp_valid <= 1'b1;
                            o_rsp_data <= sbh_lane(link.sys_addr_data, WIDE);
                            o_rsp_cmd <= link.sys_command_id;
                        end
                        if (!agent_wants) begin
                            link.release_n <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // Parity output is tied low rather than computed
    assign link.cmdp_dev = SBH_CMD_PARITY;
endmodule

/* design/sbh_if.sv */
// Pin-level link between the device end and the agent end
`timescale 1ns/1ns
interface sbh_if;
    import sbh_pkg::*;
    // Shared bus, one driver set per party
    logic [SBH_AD_W-1:0] ad_dev;
    logic ad_dev_oe;
    logic [SBH_AD_W-1:0] ad_agt;
    logic ad_agt_oe;
    logic [SBH_CHK_W-1:0] chk_dev;
    logic [SBH_CHK_W-1:0] chk_agt;
    logic [SBH_CMD_W-1:0] cmd_dev;
    logic [SBH_CMD_W-1:0] cmd_agt;
    logic cmdp_dev;
    // Output-only device pins with their enables
    logic outbound_valid_n;
    logic outbound_valid_oe;
    logic release_n;
    logic release_oe;
    logic ref_tick;
    // Agent pins
    logic agent_request_n;
    logic read_accept_n;
    logic write_accept_n;
    logic inbound_valid_n;
    // Resolved levels; an undriven bus reads as zero
    logic [SBH_AD_W-1:0] sys_addr_data;
    logic [SBH_CHK_W-1:0] sys_check_bits;
    logic [SBH_CMD_W-1:0] sys_command_id;
    logic command_parity_bit;
    logic outbound_valid_pin_n;
    logic release_pin_n;

    assign sys_addr_data = ad_dev_oe ? ad_dev : (ad_agt_oe ? ad_agt : '0);
    assign sys_check_bits = ad_dev_oe ? chk_dev : (ad_agt_oe ? chk_agt : '0);
    assign sys_command_id = ad_dev_oe ? cmd_dev : (ad_agt_oe ? cmd_agt : '0);
    assign command_parity_bit = ad_dev_oe ? cmdp_dev : 1'b0;
    // Undriven strobes float high through the board pull-ups
    assign outbound_valid_pin_n = outbound_valid_oe ? outbound_valid_n : 1'b1;
    assign release_pin_n = release_oe ? release_n : 1'b1;

    modport device (
        output ad_dev, ad_dev_oe, chk_dev, cmd_dev, cmdp_dev,
        output outbound_valid_n, outbound_valid_oe, release_n, release_oe, ref_tick,
        input sys_addr_data, sys_check_bits, sys_command_id,
        input agent_request_n, read_accept_n, write_accept_n, inbound_valid_n
    );
    modport agent (
        output ad_agt, ad_agt_oe, chk_agt, cmd_agt,
        output agent_request_n, read_accept_n, write_accept_n, inbound_valid_n,
        input sys_addr_data, sys_check_bits, sys_command_id, command_parity_bit,
        input outbound_valid_pin_n, release_pin_n, ref_tick
    );
endinterface

/* design/sbh_pkg.sv */
// Shared constants, command codes and helpers for the system bus handshake
package sbh_pkg;
    // Bus widths
    localparam int SBH_AD_W = 64;
    localparam int SBH_ADDR_W = 32;
    localparam int SBH_CHK_W = 8;
    localparam int SBH_CHK_NARROW_W = 4;
    localparam int SBH_CMD_W = 9;
    // Pipeline multiplier range and default
    localparam int SBH_MULT_MIN = 2;
    localparam int SBH_MULT_MAX = 8;
    localparam int SBH_MULT_DEF = 2;
    // Request FIFO depth
    localparam int SBH_FIFO_DEPTH = 8;
    // Command and identifier codes on the command bus
    localparam logic [SBH_CMD_W-1:0] SBH_CMD_READ = 9'h000;
    localparam logic [SBH_CMD_W-1:0] SBH_CMD_WRITE = 9'h080;
    localparam logic [SBH_CMD_W-1:0] SBH_CMD_DATA = 9'h100;
    localparam logic SBH_CMD_PARITY = 1'b0;
    localparam logic [SBH_CHK_W-1:0] SBH_CHK_ZERO = 8'h00;
    localparam logic [SBH_AD_W-SBH_ADDR_W-1:0] SBH_UPPER_ZERO = 32'h0000_0000;

    typedef logic [SBH_AD_W-1:0] sbh_word_t;

    // Byte parity check bits; narrow mode keeps only the low four lanes
    function automatic logic [SBH_CHK_W-1:0] sbh_check(input sbh_word_t d, input logic wide);
        logic [SBH_CHK_W-1:0] c;
        c = SBH_CHK_ZERO;
        for (int i = 0; i < SBH_CHK_W; i++) begin
            c[i] = ^d[i*8 +: 8];
        end
        if (!wide) begin
            c[SBH_CHK_W-1:SBH_CHK_NARROW_W] = SBH_CHK_ZERO[SBH_CHK_W-1:SBH_CHK_NARROW_W];
        end
        return c;
    endfunction

    // Narrow mode clears the unused upper half of the bus
    function automatic sbh_word_t sbh_lane(input sbh_word_t d, input logic wide);
        return wide ? d : {SBH_UPPER_ZERO, d[SBH_ADDR_W-1:0]};
    endfunction
endpackage
